// ---- include/qtc_defs.svh ----
// register offsets, field positions, codes and reset values of the quad timer
`ifndef QTC_DEFS_SVH
`define QTC_DEFS_SVH

// ==========================================================
// byte offsets on the register bus
`define QTC_OFF_MODE0 8'h00
`define QTC_OFF_MODE1 8'h04
`define QTC_OFF_MODE2 8'h08
`define QTC_OFF_MODE3 8'h0C
`define QTC_OFF_CNT0 8'h10
`define QTC_OFF_DATA1 8'h14
`define QTC_OFF_CNT1 8'h18
`define QTC_OFF_DATA2 8'h1C
`define QTC_OFF_CNT2 8'h20
`define QTC_OFF_DATA3 8'h24
`define QTC_OFF_CNT3 8'h28
`define QTC_OFF_EDGE 8'h2C
`define QTC_OFF_PORT 8'h30
`define QTC_OFF_FLAG 8'h34

// ==========================================================
// field positions
`define QTC_RUN_BIT 3
`define QTC_PWM_BIT 4
`define QTC_CAP_BIT 5
`define QTC_CASC_BIT 6
`define QTC_EVT_SEL_BIT 0
`define QTC_ROUTE_BIT 1

// ==========================================================
// codes and reset values
`define QTC_EVT_CODE 3'b111
`define QTC_CASC_CODE 2'b11
`define QTC_EDGE_FALL 2'b00
`define QTC_EDGE_RISE 2'b01
`define QTC_PRE_W 11
`define QTC_BYTE_RST 8'h00
`define QTC_PORT_RST 2'b00
`define QTC_WORD_RST 32'h0000_0000

`endif

// ---- include/qtc_pkg.sv ----
// types of the quad timer block
`default_nettype none
`include "qtc_defs.svh"

package qtc_pkg;

  typedef logic [7:0] byte_t;

  // ==========================================================
  // whole state of the timer block
  typedef struct packed {
    logic [`QTC_PRE_W-1:0] prescale;
    logic [3:0][7:0] count;
    logic [3:0][7:0] data;
    logic [3:0][7:0] capture;
    logic [3:0][7:0] mode;
    byte_t edgeSel;
    logic [1:0] portFunc;
    byte_t flags;
    logic cmpOut;
    logic ack;
    logic [31:0] rdData;
  } qtc_state_s;

  // ==========================================================
  // state of one pin synchroniser
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_state_s;

endpackage

`default_nettype wire

// ---- rtl/pin_sync_edge.sv ----
// two-flop pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none

module pin_sync_edge (
  input wire logic clk_sys,
  input wire logic rstSyncB,
  input wire logic pinIn,
  output logic rise,
  output logic fall
);

  qtc_pkg::sync_state_s s_r;
  qtc_pkg::sync_state_s s_nxt;

  // ==========================================================
  // state
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = pinIn;
    s_nxt.sync = s_r.meta;
    s_nxt.last = s_r.sync;
  end

  always_ff @(posedge clk_sys or negedge rstSyncB) begin
    if (!rstSyncB) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // only the second and third stage are looked at
  assign rise = s_r.sync & ~s_r.last;
  assign fall = ~s_r.sync & s_r.last;

  // ==========================================================
  // checks
  chk_single_edge: assert property (@(posedge clk_sys) disable iff (!rstSyncB)
    (rise || fall) |=> !(rise || fall))
    else $error("pin edge reported on two cycles in a row");

endmodule // pin_sync_edge

`default_nettype wire

// ---- rtl/quad_timer_counter_capture.sv ----
// four 8-bit timer/counters with cascade, capture and compare output
// What this block does
// - four independent 8-bit timers, each with count and match data register
// - timers 0/2 divide by 2..2048 on 3 bits; timers 1/3 by 1, 2, 8
// - count rises from zero to match, then clears on next tick, flag latched
// - timer zero data and count share one address: write data, read count
// - only timer zero counts rising edges of the event pin when selected
// - mode from cascade bit, capture bit, clock codes; 111 event, cascade needs 11
// - cascaded pair is a 16-bit counter; match flags only the lower timer
// - in capture mode counting and match flag continue as usual
// - selected capture edge copies count to capture register, then clears count
// - capture edge falling, rising or both; each such edge sets pin flag
// - timer zero shared address reads capture in capture mode, else count
// - timer one count/capture share a read address; data sits elsewhere
// - cascaded capture works over the full 16-bit count
// - in compare output mode each timer two match drives the compare pin, unless timer three has its PWM bit set
// - compare pin toggles per match, giving a 50/50 square wave
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "qtc_defs.svh"

module quad_timer_counter_capture #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic eventCountPin,
  input wire logic [3:0] captureEdgePin,
  output logic compareOutputPin,
  output logic [3:0] timerIrqFlag,
  output logic [3:0] captureIrqFlag
);

  // ==========================================================
  // reset release
  logic [1:0] rstPipe_r;
  logic rstSyncB;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe_r <= 2'b00;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstSyncB = rstPipe_r[1];

  // ==========================================================
  // pin synchronisers
  logic evRise;
  logic [3:0] capRise;
  logic [3:0] capFall;

  pin_sync_edge u_evt_sync (
    .clk_sys(clk_sys),
    .rstSyncB(rstSyncB),
    .pinIn(eventCountPin),
    .rise(evRise),
    .fall()
  );

  for (genvar g = 0; g < 4; g++) begin : g_cap_sync
    pin_sync_edge u_cap_sync (
      .clk_sys(clk_sys),
      .rstSyncB(rstSyncB),
      .pinIn(captureEdgePin[g]),
      .rise(capRise[g]),
      .fall(capFall[g])
    );
  end

  // ==========================================================
  // clock sources and mode decode
  qtc_pkg::qtc_state_s s_r;
  qtc_pkg::qtc_state_s s_nxt;

  function automatic logic evenDiv(input logic [2:0] code, input logic [`QTC_PRE_W-1:0] pre);
    unique case (code)
      3'b000: return pre[0];
      3'b001: return &pre[1:0];
      3'b010: return &pre[2:0];
      3'b011: return &pre[4:0];
      3'b100: return &pre[6:0];
      3'b101: return &pre[8:0];
      3'b110: return &pre[10:0];
      3'b111: return 1'b0;
    endcase
  endfunction

  function automatic logic oddDiv(input logic [1:0] code, input logic [`QTC_PRE_W-1:0] pre);
    unique case (code)
      2'b00: return 1'b1;
      2'b01: return pre[0];
      2'b10: return &pre[2:0];
      2'b11: return 1'b0;
    endcase
  endfunction

  logic [3:0] srcTick;
  logic [3:0] tickT;
  logic [1:0] casc;
  logic [3:0] qualEdge;
  logic [3:0] capHit;
  logic [3:0] matchEv;
  logic cmpEn;
  logic [7:0] rd0Exp;

  always_comb begin
    logic [1:0] es;
    es = 2'b00;
    // event counting only on timer zero; code 111 elsewhere stops the timer
    srcTick[0] = (s_r.mode[0][2:0] == `QTC_EVT_CODE) ?
      (s_r.portFunc[`QTC_EVT_SEL_BIT] & evRise) : evenDiv(s_r.mode[0][2:0], s_r.prescale);
    srcTick[1] = oddDiv(s_r.mode[1][1:0], s_r.prescale);
    srcTick[2] = evenDiv(s_r.mode[2][2:0], s_r.prescale);
    srcTick[3] = oddDiv(s_r.mode[3][1:0], s_r.prescale);
    for (int i = 0; i < 4; i++) begin
      tickT[i] = s_r.mode[i][`QTC_RUN_BIT] & srcTick[i];
      es = s_r.edgeSel[2*i +: 2];
      if (es == `QTC_EDGE_FALL) begin
        qualEdge[i] = capFall[i];
      end else if (es == `QTC_EDGE_RISE) begin
        qualEdge[i] = capRise[i];
      end else begin
        qualEdge[i] = capRise[i] | capFall[i];
      end
      capHit[i] = qualEdge[i] & s_r.mode[i][`QTC_CAP_BIT];
    end
    for (int p = 0; p < 2; p++) begin
      casc[p] = s_r.mode[2*p+1][`QTC_CASC_BIT] & (s_r.mode[2*p+1][1:0] == `QTC_CASC_CODE);
      if (casc[p]) begin
        matchEv[2*p] = tickT[2*p] &
          ({s_r.count[2*p+1], s_r.count[2*p]} == {s_r.data[2*p+1], s_r.data[2*p]});
        matchEv[2*p+1] = 1'b0;
      end else begin
        matchEv[2*p] = tickT[2*p] & (s_r.count[2*p] == s_r.data[2*p]);
        matchEv[2*p+1] = tickT[2*p+1] & (s_r.count[2*p+1] == s_r.data[2*p+1]);
      end
    end
    cmpEn = s_r.portFunc[`QTC_ROUTE_BIT] & ~s_r.mode[3][`QTC_PWM_BIT];
    rd0Exp = s_r.mode[0][`QTC_CAP_BIT] ? s_r.capture[0] : s_r.count[0];
  end

  // ==========================================================
  // next state
  logic busReq;
  assign busReq = wb_cyc_i & wb_stb_i & ~s_r.ack;

  always_comb begin
    logic [15:0] c16;
    logic [7:0] clrF;
    c16 = 16'h0000;
    clrF = 8'h00;
    s_nxt = s_r;
    s_nxt.prescale = `QTC_PRE_W'(s_r.prescale + 11'h001);

    for (int p = 0; p < 2; p++) begin
      if (casc[p]) begin
        c16 = {s_r.count[2*p+1], s_r.count[2*p]};
        if (tickT[2*p]) begin
          c16 = matchEv[2*p] ? 16'h0000 : 16'(c16 + 16'h0001);
        end
        // capture wins over a tick landing in the same cycle
        if (capHit[2*p]) begin
          s_nxt.capture[2*p+1] = s_r.count[2*p+1];
          s_nxt.capture[2*p] = s_r.count[2*p];
          c16 = 16'h0000;
        end
        s_nxt.count[2*p+1] = c16[15:8];
        s_nxt.count[2*p] = c16[7:0];
      end else begin
        for (int k = 2*p; k < 2*p+2; k++) begin
          if (tickT[k]) begin
            s_nxt.count[k] = matchEv[k] ? 8'h00 : 8'(s_r.count[k] + 8'h01);
          end
          if (capHit[k]) begin
            s_nxt.capture[k] = s_r.count[k];
            s_nxt.count[k] = 8'h00;
          end
        end
      end
    end

    if (matchEv[2] && cmpEn) begin
      s_nxt.cmpOut = ~s_r.cmpOut;
    end

    // register bus: one wait state, data in the low byte lane
    s_nxt.ack = busReq;
    if (busReq && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i[7:0])
        `QTC_OFF_MODE0: s_nxt.mode[0] = wb_dat_i[7:0];
        `QTC_OFF_MODE1: s_nxt.mode[1] = wb_dat_i[7:0];
        `QTC_OFF_MODE2: s_nxt.mode[2] = wb_dat_i[7:0];
        `QTC_OFF_MODE3: s_nxt.mode[3] = wb_dat_i[7:0];
        `QTC_OFF_CNT0: s_nxt.data[0] = wb_dat_i[7:0];
        `QTC_OFF_DATA1: s_nxt.data[1] = wb_dat_i[7:0];
        `QTC_OFF_DATA2: s_nxt.data[2] = wb_dat_i[7:0];
        `QTC_OFF_DATA3: s_nxt.data[3] = wb_dat_i[7:0];
        `QTC_OFF_EDGE: s_nxt.edgeSel = wb_dat_i[7:0];
        `QTC_OFF_PORT: s_nxt.portFunc = wb_dat_i[1:0];
        `QTC_OFF_FLAG: clrF = wb_dat_i[7:0];
        default: clrF = 8'h00;
      endcase
    end
    if (busReq && !wb_we_i) begin
      s_nxt.rdData = `QTC_WORD_RST;
      case (wb_adr_i[7:0])
        `QTC_OFF_MODE0: s_nxt.rdData[7:0] = s_r.mode[0];
        `QTC_OFF_MODE1: s_nxt.rdData[7:0] = s_r.mode[1];
        `QTC_OFF_MODE2: s_nxt.rdData[7:0] = s_r.mode[2];
        `QTC_OFF_MODE3: s_nxt.rdData[7:0] = s_r.mode[3];
        `QTC_OFF_CNT0: s_nxt.rdData[7:0] = rd0Exp;
        `QTC_OFF_DATA1: s_nxt.rdData[7:0] = s_r.data[1];
        `QTC_OFF_CNT1: s_nxt.rdData[7:0] = s_r.mode[1][`QTC_CAP_BIT] ? s_r.capture[1] : s_r.count[1];
        `QTC_OFF_DATA2: s_nxt.rdData[7:0] = s_r.data[2];
        `QTC_OFF_CNT2: s_nxt.rdData[7:0] = s_r.mode[2][`QTC_CAP_BIT] ? s_r.capture[2] : s_r.count[2];
        `QTC_OFF_DATA3: s_nxt.rdData[7:0] = s_r.data[3];
        `QTC_OFF_CNT3: s_nxt.rdData[7:0] = s_r.mode[3][`QTC_CAP_BIT] ? s_r.capture[3] : s_r.count[3];
        `QTC_OFF_EDGE: s_nxt.rdData[7:0] = s_r.edgeSel;
        `QTC_OFF_PORT: s_nxt.rdData[1:0] = s_r.portFunc;
        `QTC_OFF_FLAG: s_nxt.rdData[7:0] = s_r.flags;
        default: s_nxt.rdData = `QTC_WORD_RST;
      endcase
    end

    // a new event beats a clear written in the same cycle
    s_nxt.flags = (s_r.flags & ~clrF) | {qualEdge, matchEv};
  end

  always_ff @(posedge clk_sys or negedge rstSyncB) begin
    if (!rstSyncB) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.rdData;
  assign wb_ack_o = s_r.ack;
  assign compareOutputPin = s_r.cmpOut;
  assign timerIrqFlag = s_r.flags[3:0];
  assign captureIrqFlag = s_r.flags[7:4];

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstSyncB);

  chk_count_step: assert property (
    (tickT[1] && !casc[0] && !matchEv[1] && !capHit[1]) |=> s_r.count[1] == 8'($past(s_r.count[1]) + 8'h01))
    else $error("timer one did not advance by one on its tick");

  chk_div_two: assert property (
    (s_r.mode[2][2:0] == 3'b000 && srcTick[2]) |=> !srcTick[2])
    else $error("divide-by-two source ticked twice in a row");

  chk_wrap_zero: assert property (
    (matchEv[0] && !casc[0]) |=> (s_r.count[0] == 8'h00 && s_r.flags[0]))
    else $error("timer zero did not clear and flag on match");

  chk_shared_read: assert property (
    (busReq && !wb_we_i && wb_adr_i[7:0] == `QTC_OFF_CNT0) |=> wb_ack_o && wb_dat_o[7:0] == $past(rd0Exp))
    else $error("shared timer zero address returned wrong value");

  chk_event_tick: assert property (
    (s_r.mode[0][2:0] == `QTC_EVT_CODE && s_r.mode[0][`QTC_RUN_BIT] && s_r.portFunc[`QTC_EVT_SEL_BIT] && evRise)
    |-> tickT[0])
    else $error("event pin edge not counted");

  chk_casc_flag: assert property (
    (casc[0] && !s_r.flags[1]) |=> !s_r.flags[1])
    else $error("upper timer flagged while cascaded");

  chk_capture_clear: assert property (
    (capHit[0] && !casc[0]) |=> (s_r.count[0] == 8'h00 && s_r.capture[0] == $past(s_r.count[0])))
    else $error("capture did not copy and clear the count");

  chk_pin_flag: assert property (
    qualEdge[2] |=> s_r.flags[6])
    else $error("capture pin edge did not set its flag");

  chk_cmp_toggle: assert property (
    (matchEv[2] && cmpEn) |=> compareOutputPin != $past(compareOutputPin))
    else $error("compare pin did not toggle on match");

  chk_cmp_hold: assert property (
    !(matchEv[2] && cmpEn) |=> $stable(compareOutputPin))
    else $error("compare pin moved without a match");

  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held for two cycles");

  cov_wrap: cover property (matchEv[0] && !casc[0]);
  cov_casc_match: cover property (matchEv[2] && casc[1]);
  cov_capture: cover property (capHit[1]);
  cov_cmp_toggle: cover property (matchEv[2] && cmpEn);

endmodule // quad_timer_counter_capture

`default_nettype wire

// ---- tb/pin_partner.sv ----
// partner model for the event, capture and compare pins of the quad timer
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
  input wire logic clk_sys,
  input wire logic compareOutputPin,
  output logic eventCountPin,
  output logic [3:0] captureEdgePin,
  output int toggleCnt
);
  logic lastCmp;

  // ==========================================================
  // idle levels and compare pin watch
  initial begin
    eventCountPin = 1'b0;
    captureEdgePin = 4'h0;
    toggleCnt = 0;
    lastCmp = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (compareOutputPin !== lastCmp) begin
        toggleCnt++;
      end
      lastCmp = compareOutputPin;
    end
  end

  // ==========================================================
  // pin pulses, 4 clocks per level so the two-flop sync sees each edge once
  task automatic pulse_event(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      eventCountPin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      eventCountPin <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask

  task automatic pulse_capture(input int idx);
    @(posedge clk_sys);
    captureEdgePin[idx] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    captureEdgePin[idx] <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule // pin_partner

`default_nettype wire

// ---- tb/tb_quad_timer_counter_capture.sv ----
// self-checking bench of the quad timer over classic wishbone
`timescale 1ns/1ps
`default_nettype none
`include "qtc_defs.svh"

module tb_quad_timer_counter_capture;
  logic clk_sys;
  logic rst_b;
  logic [7:0] wbAdr;
  logic [31:0] wbDatI;
  logic [31:0] wbDatO;
  logic [31:0] rd;
  logic [3:0] wbSel;
  logic wbWe;
  logic wbCyc;
  logic wbStb;
  logic wbAck;
  logic eventCountPin;
  logic [3:0] captureEdgePin;
  logic compareOutputPin;
  logic [3:0] timerIrqFlag;
  logic [3:0] captureIrqFlag;
  int toggleCnt;
  int error_cnt = 0;
  int samples_checked = 0;
  int mark;

  quad_timer_counter_capture i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_ack_o(wbAck),
    .eventCountPin(eventCountPin), .captureEdgePin(captureEdgePin), .compareOutputPin(compareOutputPin),
    .timerIrqFlag(timerIrqFlag), .captureIrqFlag(captureIrqFlag)
  );

  pin_partner i_pins (
    .clk_sys(clk_sys), .compareOutputPin(compareOutputPin), .eventCountPin(eventCountPin),
    .captureEdgePin(captureEdgePin), .toggleCnt(toggleCnt)
  );

  // ==========================================================
  // clock, watchdog, closing
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #100_000;
    error_cnt++;
    $display("Error watchdog expired");
    end_of_test();
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ==========================================================
  // bus cycle: request held until ack is sampled high
  task automatic wb_cycle(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    wbAdr <= a;
    wbWe <= we;
    wbDatI <= d;
    wbSel <= 4'hF;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rd = wbDatO;
    if (n >= 20) check("ack", 32'h0000_0001, 32'h0000_0000);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb_cycle(a, 1'b1, {24'h00_0000, d});
  endtask

  // waits on one bit of {pin flags, match flags}
  task automatic wait_flag(input int b, input int lim);
    int n;
    n = 0;
    while ((b < 4 ? timerIrqFlag[b] : captureIrqFlag[b - 4]) !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    wb_cycle(`QTC_OFF_MODE0, 1'b0, 32'h0000_0000);
    check("mode0 reset", 32'h0000_0000, rd);
    wb_cycle(`QTC_OFF_FLAG, 1'b0, 32'h0000_0000);
    check("flags reset", 32'h0000_0000, rd);
    wr(8'h3C, 8'h5A);
    wb_cycle(8'h3C, 1'b0, 32'h0000_0000);
    check("unmapped", 32'h0000_0000, rd);
    $display("test reset done");
  endtask

  // 16-bit match 0x0102 at /2 takes about 518 clocks; 8-bit mode would flag within 6
  task automatic t_cascade();
    wr(`QTC_OFF_CNT0, 8'h02);
    wr(`QTC_OFF_DATA1, 8'h01);
    wr(`QTC_OFF_MODE1, 8'h43);
    wr(`QTC_OFF_MODE0, 8'h08);
    repeat (100) @(posedge clk_sys);
    check("cascade early", 32'h0000_0000, {28'h000_0000, timerIrqFlag});
    wait_flag(0, 1200);
    check("cascade flags", 32'h0000_0001, {28'h000_0000, timerIrqFlag});
    wr(`QTC_OFF_MODE0, 8'h00);
    wr(`QTC_OFF_MODE1, 8'h00);
    wr(`QTC_OFF_FLAG, 8'hFF);
    $display("test cascade done");
  endtask

  task automatic t_match();
    wr(`QTC_OFF_DATA1, 8'h03);
    wr(`QTC_OFF_MODE1, 8'h08);
    wait_flag(1, 40);
    check("timer1 flag", 32'h0000_0002, {28'h000_0000, timerIrqFlag});
    wr(`QTC_OFF_MODE1, 8'h00);
    wb_cycle(`QTC_OFF_CNT1, 1'b0, 32'h0000_0000);
    check("count1 max", 32'h0000_0001, {31'h0, rd <= 32'h0000_0003});
    wr(`QTC_OFF_FLAG, 8'hFF);
    check("flags cleared", 32'h0000_0000, {28'h000_0000, timerIrqFlag});
    $display("test match done");
  endtask

  task automatic t_event_capture();
    wr(`QTC_OFF_PORT, 8'h01);
    wr(`QTC_OFF_CNT0, 8'hC8);
    wr(`QTC_OFF_MODE0, 8'h0F);
    // count0 keeps the few ticks after the cascade run, so counts are relative
    wb_cycle(`QTC_OFF_CNT0, 1'b0, 32'h0000_0000);
    mark = rd;
    i_pins.pulse_event(3);
    wb_cycle(`QTC_OFF_CNT0, 1'b0, 32'h0000_0000);
    check("event count", 32'(mark + 3), rd);
    wr(`QTC_OFF_EDGE, 8'h01);
    wr(`QTC_OFF_MODE0, 8'h2F);
    i_pins.pulse_event(2);
    i_pins.pulse_capture(0);
    check("pin flag", 32'h0000_0001, {28'h000_0000, captureIrqFlag});
    wb_cycle(`QTC_OFF_CNT0, 1'b0, 32'h0000_0000);
    check("capture0", 32'(mark + 5), rd);
    wr(`QTC_OFF_MODE0, 8'h0F);
    wb_cycle(`QTC_OFF_CNT0, 1'b0, 32'h0000_0000);
    check("count0 cleared", 32'h0000_0000, rd);
    wr(`QTC_OFF_MODE0, 8'h00);
    wr(`QTC_OFF_FLAG, 8'hFF);
    $display("test event capture done");
  endtask

  // data 1 at /2 gives a toggle every 4 clocks, so 9 to 11 in 40
  task automatic t_compare();
    wr(`QTC_OFF_PORT, 8'h02);
    wr(`QTC_OFF_DATA2, 8'h01);
    wr(`QTC_OFF_MODE2, 8'h08);
    repeat (8) @(posedge clk_sys);
    mark = toggleCnt;
    repeat (40) @(posedge clk_sys);
    mark = toggleCnt - mark;
    check("toggle rate", 32'h0000_0001, {31'h0, mark >= 9 && mark <= 11});
    wr(`QTC_OFF_MODE3, 8'h10);
    repeat (4) @(posedge clk_sys);
    mark = toggleCnt;
    repeat (40) @(posedge clk_sys);
    check("pwm blocks pin", mark, toggleCnt);
    $display("test compare done");
  endtask

  // pair 2/3 at /2 for about 710 clocks: 16-bit count lies in 0x0100..0x01FF
  task automatic t_casc_capture();
    wr(`QTC_OFF_DATA3, 8'h10);
    wr(`QTC_OFF_MODE3, 8'h63);
    wr(`QTC_OFF_MODE2, 8'h28);
    repeat (700) @(posedge clk_sys);
    i_pins.pulse_capture(2);
    wb_cycle(`QTC_OFF_CNT3, 1'b0, 32'h0000_0000);
    check("capture3 upper", 32'h0000_0001, rd);
    check("pin2 flag", 32'h0000_0004, {28'h000_0000, captureIrqFlag});
    wr(`QTC_OFF_MODE2, 8'h00);
    wr(`QTC_OFF_MODE3, 8'h00);
    wr(`QTC_OFF_FLAG, 8'hFF);
    $display("test cascade capture done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    wbAdr = 8'h00;
    wbDatI = 32'h0000_0000;
    wbSel = 4'h0;
    wbWe = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_cascade();
    t_match();
    t_event_capture();
    t_compare();
    t_casc_capture();
    end_of_test();
  end
endmodule // tb_quad_timer_counter_capture

`default_nettype wire
